// file: hdl/cgc_pkg.sv
package cgc_pkg;
    // Register offsets on the plain register port
    localparam logic [2:0] CGC_ADDR_STATUS_CONTROL = 3'h0;
    localparam logic [2:0] CGC_ADDR_CONTROL_THREE  = 3'h1;
    localparam logic [2:0] CGC_ADDR_MODE           = 3'h2;
    localparam logic [2:0] CGC_ADDR_IRQ_STATUS     = 3'h3;
    localparam logic [2:0] CGC_ADDR_IRQ_MASK       = 3'h4;

    // Status and control field positions
    localparam int CGC_SC_LOCK_LOSS  = 7;
    localparam int CGC_SC_OSC_READY  = 1;
    localparam int CGC_SC_FINE_TRIM  = 0;

    // Control three field positions
    localparam int CGC_C3_LOCK_LOSS_IRQ_ENABLE      = 7;
    localparam int CGC_C3_PLL_SEL    = 6;
    localparam int CGC_C3_CLK_MON    = 5;
    localparam int CGC_C3_DIV_EN     = 4;

    // Mode register field positions
    localparam int CGC_MD_EXT_EN     = 3;
    localparam int CGC_MD_OSC_SEL    = 4;
    localparam int CGC_MD_RANGE      = 5;

    // Interrupt status bit positions
    localparam int CGC_IRQ_LOCK_LOSS = 0;
    localparam int CGC_IRQ_OSC_READY = 1;
    localparam int CGC_IRQ_CLK_LOSS  = 2;

    // Reset values
    localparam logic [7:0] CGC_C3_RESET   = 8'h01;
    localparam logic [7:0] CGC_MODE_RESET = 8'h00;
    localparam logic [3:0] CGC_VCO_MULT_SELECT_RESET = 4'h1;
    localparam logic       CGC_TRIM_DEBUG = 1'b0;

    // External reference divide factor
    localparam int CGC_EXTRA_DIV = 32;

    // Oscillator start-up cycles
    localparam int CGC_OSC_INIT_CYCLES = 4096;

    // Operating modes (coded in the mode register, bits 2:0)
    typedef enum logic [2:0] {
        CGC_FEI  = 3'h0,
        CGC_FEE  = 3'h1,
        CGC_FBI  = 3'h2,
        CGC_FBE  = 3'h3,
        CGC_PEE  = 3'h4,
        CGC_PBE  = 3'h5,
        CGC_BYPASSED_LOW_POWER_INT_MODE = 3'h6,
        CGC_BYPASSED_LOW_POWER_EXT_MODE = 3'h7
    } cgc_mode_t;

    function automatic logic cgc_mode_is_ext(input logic [2:0] m);
        cgc_mode_is_ext = (m == CGC_FEE) || (m == CGC_FBE) || (m == CGC_PEE) ||
                          (m == CGC_PBE) || (m == CGC_BYPASSED_LOW_POWER_EXT_MODE);
    endfunction
endpackage

// file: hdl/cgc_osc_init.sv
`timescale 1ns/1ns
// Counts oscillator start-up cycles and holds the ready flag
module cgc_osc_init
    import cgc_pkg::*;
(
    input  wire logic clock_i,
    input  wire logic resetn_i,
    input  wire logic req_i,
    input  wire logic clear_i,
    output logic      ready_o
);
    localparam int CW = $clog2(CGC_OSC_INIT_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CGC_OSC_INIT_CYCLES - 1);

    logic [CW-1:0] cnt_r;

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_r <= '0;
        end else if (clear_i || !req_i) begin
            cnt_r <= '0;
        end else if (cnt_r != LAST) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ready_o <= 1'b0;
        end else if (clear_i) begin
            ready_o <= 1'b0;
        end else if (req_i && cnt_r == LAST) begin
            ready_o <= 1'b1;
        end
    end
endmodule

// file: hdl/cgc_top.sv
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/1ns
module cgc_top
    import cgc_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       resetn_i,
    input  wire logic [2:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    input  wire logic       factory_trim_i,
    input  wire logic       debug_mode_i,
    input  wire logic       lock_lost_i,
    input  wire logic       ext_clk_lost_i,
    output logic            irq_o,
    output logic            fine_trim_bit_o,
    output logic            pll_enable_o,
    output logic            fll_enable_o,
    output logic            fll_ref_extra_ref_div_enable_o,
    output logic      [5:0] vco_mult_o,
    output logic            osc_enable_o,
    output logic            reset_req_o
);
    logic       lock_loss_sticky_r;
    logic       fine_trim_bit_r;
    logic       trim_loaded_r;
    logic       lock_loss_irq_enable_r;
    logic       pll_select_r;
    logic       clock_monitor_enable_r;
    logic       extra_ref_div_enable_r;
    logic [3:0] vco_mult_select_r;
    logic [7:0] mode_r;
    logic [2:0] irq_status_r;
    logic [2:0] irq_mask_r;
    logic       osc_ready_flag;
    logic       osc_ready_d_r;
    logic       osc_req;
    logic       osc_clr;
    logic       ext_ref_clk_enable;
    logic       ext_osc_select;
    logic       range_hi;
    logic [2:0] mode_sel;
    logic [2:0] irq_set;
    logic       wr_sc;
    logic       wr_c3;
    logic       wr_mode;
    logic       wr_ist;
    logic       wr_msk;
    logic [7:0] rdata_nxt;

    function automatic logic [5:0] vco_mult(input logic [3:0] code);
        if (code == 4'h0) begin
            vco_mult = 6'h00;
        end else if (code > 4'ha) begin
            vco_mult = 6'h28;
        end else begin
            vco_mult = {code, 2'b00};
        end
    endfunction

    assign wr_sc   = wr_i && addr_i == CGC_ADDR_STATUS_CONTROL;
    assign wr_c3   = wr_i && addr_i == CGC_ADDR_CONTROL_THREE;
    assign wr_mode = wr_i && addr_i == CGC_ADDR_MODE;
    assign wr_ist  = wr_i && addr_i == CGC_ADDR_IRQ_STATUS;
    assign wr_msk  = wr_i && addr_i == CGC_ADDR_IRQ_MASK;

    assign mode_sel           = mode_r[2:0];
    assign ext_ref_clk_enable = mode_r[CGC_MD_EXT_EN];
    assign ext_osc_select     = mode_r[CGC_MD_OSC_SEL];
    assign range_hi           = mode_r[CGC_MD_RANGE];

    assign osc_req = ext_osc_select && (ext_ref_clk_enable || cgc_mode_is_ext(mode_sel));
    assign osc_clr = !ext_osc_select ||
                     (!ext_ref_clk_enable && (mode_sel == CGC_FEI || mode_sel == CGC_FBI ||
                                              mode_sel == CGC_BYPASSED_LOW_POWER_INT_MODE));

    cgc_osc_init u_osc (
        .clock_i  (clock_i),
        .resetn_i (resetn_i),
        .req_i    (osc_req),
        .clear_i  (osc_clr),
        .ready_o  (osc_ready_flag)
    );

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mode_r <= CGC_MODE_RESET;
        end else if (wr_mode) begin
            mode_r <= wdata_i;
        end
    end

    // sticky set wins over write-one clear
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lock_loss_sticky_r <= 1'b0;
        end else if (lock_lost_i) begin
            lock_loss_sticky_r <= 1'b1;
        end else if (wr_sc && wdata_i[CGC_SC_LOCK_LOSS]) begin
            lock_loss_sticky_r <= 1'b0;
        end
    end

    // factory or debug load just after reset release
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            trim_loaded_r   <= 1'b0;
            fine_trim_bit_r <= CGC_TRIM_DEBUG;
        end else if (!trim_loaded_r) begin
            trim_loaded_r   <= 1'b1;
            fine_trim_bit_r <= debug_mode_i ? CGC_TRIM_DEBUG : factory_trim_i;
        end else if (wr_sc) begin
            fine_trim_bit_r <= wdata_i[CGC_SC_FINE_TRIM];
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lock_loss_irq_enable_r <= CGC_C3_RESET[CGC_C3_LOCK_LOSS_IRQ_ENABLE];
        end else if (wr_c3) begin
            lock_loss_irq_enable_r <= wdata_i[CGC_C3_LOCK_LOSS_IRQ_ENABLE];
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pll_select_r <= CGC_C3_RESET[CGC_C3_PLL_SEL];
        end else if (wr_c3) begin
            pll_select_r <= wdata_i[CGC_C3_PLL_SEL];
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            clock_monitor_enable_r <= CGC_C3_RESET[CGC_C3_CLK_MON];
        end else if (wr_c3) begin
            clock_monitor_enable_r <= wdata_i[CGC_C3_CLK_MON];
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            vco_mult_select_r <= CGC_VCO_MULT_SELECT_RESET;
        end else if (wr_c3) begin
            vco_mult_select_r <= wdata_i[3:0];
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            extra_ref_div_enable_r <= CGC_C3_RESET[CGC_C3_DIV_EN];
        end else if (wr_c3 && !pll_select_r) begin
            extra_ref_div_enable_r <= wdata_i[CGC_C3_DIV_EN];
        end
    end

    // Interrupt events: lock loss, oscillator ready rise, clock loss
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            osc_ready_d_r <= 1'b0;
        end else begin
            osc_ready_d_r <= osc_ready_flag;
        end
    end

    assign irq_set[CGC_IRQ_LOCK_LOSS] = lock_lost_i;
    assign irq_set[CGC_IRQ_OSC_READY] = osc_ready_flag && !osc_ready_d_r;
    assign irq_set[CGC_IRQ_CLK_LOSS]  = ext_clk_lost_i;

    generate
        for (genvar i = 0; i < 3; i++) begin : g_ist
            always_ff @(posedge clock_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    irq_status_r[i] <= 1'b0;
                end else if (irq_set[i]) begin
                    irq_status_r[i] <= 1'b1;
                end else if (wr_ist && wdata_i[i]) begin
                    irq_status_r[i] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_mask_r <= 3'h0;
        end else if (wr_msk) begin
            irq_mask_r <= wdata_i[2:0];
        end
    end

    // lock-loss request needs enable and flag
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_o <= 1'b0;
        end else begin
            // Lock-loss status bit only counts while its enable is set
            irq_o <= (lock_loss_irq_enable_r && lock_loss_sticky_r) ||
                     (|(irq_status_r & irq_mask_r & {2'b11, lock_loss_irq_enable_r}));
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reset_req_o <= 1'b0;
        end else begin
            reset_req_o <= clock_monitor_enable_r && ext_clk_lost_i;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pll_enable_o <= 1'b0;
        end else begin
            pll_enable_o <= pll_select_r;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fll_enable_o <= 1'b1;
        end else begin
            fll_enable_o <= !pll_select_r;
        end
    end

    // divide by 32 only at high range
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fll_ref_extra_ref_div_enable_o <= 1'b0;
        end else begin
            fll_ref_extra_ref_div_enable_o <= range_hi && extra_ref_div_enable_r;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            vco_mult_o <= 6'h00;
        end else begin
            vco_mult_o <= vco_mult(vco_mult_select_r);
        end
    end

    // trim bit drives the period step
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fine_trim_bit_o <= CGC_TRIM_DEBUG;
        end else begin
            fine_trim_bit_o <= fine_trim_bit_r;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            osc_enable_o <= 1'b0;
        end else begin
            osc_enable_o <= osc_req;
        end
    end

    always_comb begin
        rdata_nxt = 8'h00;
        unique case (addr_i)
            CGC_ADDR_STATUS_CONTROL: begin
                rdata_nxt[CGC_SC_LOCK_LOSS] = lock_loss_sticky_r;
                rdata_nxt[CGC_SC_OSC_READY] = osc_ready_flag;
                rdata_nxt[CGC_SC_FINE_TRIM] = fine_trim_bit_r;
            end
            CGC_ADDR_CONTROL_THREE: begin
                rdata_nxt = {lock_loss_irq_enable_r, pll_select_r, clock_monitor_enable_r,
                             extra_ref_div_enable_r, vco_mult_select_r};
            end
            CGC_ADDR_MODE:       rdata_nxt = mode_r;
            CGC_ADDR_IRQ_STATUS: rdata_nxt = {5'h00, irq_status_r};
            CGC_ADDR_IRQ_MASK:   rdata_nxt = {5'h00, irq_mask_r};
            default:             rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            rdata_o <= rdata_nxt;
        end else begin
            rdata_o <= 8'h00;
        end
    end
endmodule

// file: test/cgc_chk.sv
`timescale 1ns/1ns
module cgc_chk
    import cgc_pkg::*;
(
    input wire logic       clock_i,
    input wire logic       resetn_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic       ext_clk_lost_i,
    input wire logic       irq_o,
    input wire logic       fine_trim_bit_o,
    input wire logic       pll_enable_o,
    input wire logic       fll_enable_o,
    input wire logic [5:0] vco_mult_o,
    input wire logic       reset_req_o
);
    logic c3_wr;
    logic cme_r;
    assign c3_wr = wr_i && (addr_i == CGC_ADDR_CONTROL_THREE);
    function automatic logic [5:0] mult(input logic [3:0] c);
        return (c == 4'h0) ? 6'h00 : (c > 4'ha) ? 6'h28 : {c, 2'b00};
    endfunction
    // Mirror of the monitor enable bit
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cme_r <= 1'b0;
        end else if (c3_wr) begin
            cme_r <= wdata_i[CGC_C3_CLK_MON];
        end
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    AST_RDATA_IDLE: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data not zero outside a read");
    AST_UNMAPPED: assert property (rd_i && addr_i > 3'h4 |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    AST_PLL_FLL: assert property (pll_enable_o ^ fll_enable_o)
        else $error("pll and fll enables not exclusive");
    AST_PLL_SEL: assert property (c3_wr |-> ##2 pll_enable_o == $past(wdata_i[6], 2))
        else $error("pll enable does not follow select");
    AST_VCO: assert property (c3_wr |-> ##2 vco_mult_o == mult($past(wdata_i[3:0], 2)))
        else $error("multiplier wrong for code");
    AST_TRIM_W: assert property (wr_i && addr_i == CGC_ADDR_STATUS_CONTROL |-> ##2
        fine_trim_bit_o == $past(wdata_i[CGC_SC_FINE_TRIM], 2))
        else $error("fine trim output does not follow write");
    AST_RST_REQ: assert property (cme_r && ext_clk_lost_i |-> ##[1:2] reset_req_o)
        else $error("no reset request on clock loss");
    AST_RST_CAUSE: assert property (reset_req_o |-> $past(ext_clk_lost_i) ||
        $past(ext_clk_lost_i, 2))
        else $error("reset request without clock loss");
    COV_PLL: cover property (c3_wr ##2 pll_enable_o);
    COV_IRQ: cover property ($rose(irq_o));
    COV_RST: cover property (reset_req_o);
endmodule

// file: test/tb.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module tb;
    import cgc_pkg::*;
    logic       clock_i = 1'b0;
    logic       resetn_i = 1'b0;
    logic [2:0] addr_i = 3'h0;
    logic [7:0] wdata_i = 8'h00;
    logic       wr_i = 1'b0;
    logic       rd_i = 1'b0;
    logic       trim_i = 1'b1;
    logic       dbg_i = 1'b0;
    logic       lol_i = 1'b0;
    logic       lost_i = 1'b0;
    logic [7:0] rdata_o;
    logic       irq_o, trim_o, pll_o, fll_o, div_o, osc_o, rreq_o;
    logic [5:0] vco_o;
    logic [7:0] d, v;
    int         n_errors = 0;
    int         n_checks = 0;
    int         seed = 32'h71c6a9f7;
    always #5 clock_i = ~clock_i;
    cgc_top i_dut (.clock_i(clock_i), .resetn_i(resetn_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .factory_trim_i(trim_i), .debug_mode_i(dbg_i), .lock_lost_i(lol_i),
        .ext_clk_lost_i(lost_i), .irq_o(irq_o), .fine_trim_bit_o(trim_o),
        .pll_enable_o(pll_o), .fll_enable_o(fll_o), .fll_ref_extra_ref_div_enable_o(div_o),
        .vco_mult_o(vco_o), .osc_enable_o(osc_o), .reset_req_o(rreq_o));
    function automatic logic [5:0] exp_mult(input logic [3:0] c);
        return (c == 4'h0) ? 6'h00 : (c > 4'ha) ? 6'h28 : {c, 2'b00};
    endfunction
    task complete_run;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task wr(input logic [2:0] a, input logic [7:0] x);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= x;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask
    task rd(input logic [2:0] a, output logic [7:0] x);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 x = rdata_o;
    endtask
    task settle;
        repeat (2) @(posedge clock_i);
        #1;
    endtask
    task pulse(input int lock);
        @(posedge clock_i);
        if (lock != 0) lol_i <= 1'b1; else lost_i <= 1'b1;
        @(posedge clock_i);
        lol_i <= 1'b0;
        lost_i <= 1'b0;
        settle();
    endtask
    task rst(input logic dbg, input logic ft);
        @(posedge clock_i);
        dbg_i <= dbg;
        trim_i <= ft;
        resetn_i <= 1'b0;
        repeat (8) @(posedge clock_i);
        resetn_i <= 1'b1;
        settle();
    endtask
    initial begin
        rst(1'b0, 1'b1);
        rd(CGC_ADDR_CONTROL_THREE, d);
        `CHK("c3 reset", CGC_C3_RESET, d)
        rd(CGC_ADDR_STATUS_CONTROL, d);
        `CHK("trim load", 1'b1, d[CGC_SC_FINE_TRIM])
        `CHK("trim out", 1'b1, trim_o)
        `CHK("fll reset", 1'b1, fll_o)
        `CHK("vco reset", 6'h04, vco_o)
        $display("reset test done");
        for (int c = 0; c < 16; c++) begin
            v = {1'b0, 1'($random(seed)), 2'b00, 4'(c)};
            wr(CGC_ADDR_CONTROL_THREE, v);
            settle();
            `CHK("vco", exp_mult(v[3:0]), vco_o)
            `CHK("pll", v[6], pll_o)
            `CHK("fll", ~v[6], fll_o)
            rd(CGC_ADDR_CONTROL_THREE, d);
            `CHK("c3", v, d)
            wr(3'(5 + c % 3), 8'hff);
            rd(3'(5 + c % 3), d);
            `CHK("unmapped", 8'h00, d)
        end
        $display("multiplier test done");
        wr(1, 8'h01);
        wr(2, 8'h20);
        wr(1, 8'h11);
        settle();
        `CHK("div on", 1'b1, div_o)
        wr(2, 8'h00);
        settle();
        `CHK("div range off", 1'b0, div_o)
        wr(2, 8'h20);
        wr(1, 8'h51);
        wr(1, 8'h41);
        rd(1, d);
        `CHK("div kept", 8'h51, d)
        `CHK("div kept out", 1'b1, div_o)
        wr(1, 8'h11);
        wr(1, 8'h01);
        wr(2, 8'h00);
        $display("divider test done");
        pulse(1);
        rd(0, d);
        `CHK("sticky set", 1'b1, d[CGC_SC_LOCK_LOSS])
        `CHK("irq off", 1'b0, irq_o)
        wr(1, 8'h81);
        settle();
        `CHK("irq on", 1'b1, irq_o)
        wr(0, 8'h01);
        rd(0, d);
        `CHK("sticky w0", 1'b1, d[CGC_SC_LOCK_LOSS])
        `CHK("trim set", 1'b1, d[CGC_SC_FINE_TRIM])
        wr(0, 8'h80);
        settle();
        rd(0, d);
        `CHK("sticky w1", 1'b0, d[CGC_SC_LOCK_LOSS])
        `CHK("trim clear", 1'b0, trim_o)
        `CHK("irq cleared", 1'b0, irq_o)
        wr(3, 8'h07);
        wr(1, 8'h01);
        wr(4, 8'h04);
        pulse(0);
        `CHK("masked irq", 1'b1, irq_o)
        wr(3, 8'h04);
        settle();
        `CHK("irq w1c", 1'b0, irq_o)
        wr(2, 8'h08);
        wr(1, 8'h21);
        @(posedge clock_i);
        lost_i <= 1'b1;
        settle();
        `CHK("reset req", 1'b1, rreq_o)
        wr(1, 8'h01);
        settle();
        `CHK("monitor off", 1'b0, rreq_o)
        @(posedge clock_i);
        lost_i <= 1'b0;
        wr(4, 8'h00);
        wr(3, 8'h07);
        $display("interrupt test done");
        wr(2, 8'h11);
        repeat (4000) @(posedge clock_i);
        rd(0, d);
        `CHK("osc early", 1'b0, d[CGC_SC_OSC_READY])
        repeat (200) @(posedge clock_i);
        rd(0, d);
        `CHK("osc ready", 1'b1, d[CGC_SC_OSC_READY])
        `CHK("osc enable", 1'b1, osc_o)
        rd(3, d);
        `CHK("osc irq", 1'b1, d[CGC_IRQ_OSC_READY])
        wr(2, 8'h18);
        rd(0, d);
        `CHK("osc held", 1'b1, d[CGC_SC_OSC_READY])
        wr(2, 8'h10);
        rd(0, d);
        `CHK("osc cleared", 1'b0, d[CGC_SC_OSC_READY])
        `CHK("osc enable off", 1'b0, osc_o)
        $display("oscillator test done");
        rst(1'b0, 1'b0);
        `CHK("trim load 0", 1'b0, trim_o)
        rst(1'b1, 1'b1);
        `CHK("trim debug", 1'b0, trim_o)
        rd(1, d);
        `CHK("c3 reset 2", CGC_C3_RESET, d)
        $display("debug reset test done");
        complete_run();
    end
    initial begin
        #300000;
        n_errors++;
        complete_run();
    end
endmodule
bind cgc_top cgc_chk i_chk (.clock_i(clock_i), .resetn_i(resetn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .ext_clk_lost_i(ext_clk_lost_i), .irq_o(irq_o), .fine_trim_bit_o(fine_trim_bit_o),
    .pll_enable_o(pll_enable_o), .fll_enable_o(fll_enable_o), .vco_mult_o(vco_mult_o),
    .reset_req_o(reset_req_o));
